// ==== rtl/supply_monitor.sv ====
// supply monitor control: hysteretic flag, reset request, write-once config, apb
//
// Behaviour
// - flag sets below falling trip, clears above rising trip, else holds
// - trip-range select reads zero after power-on reset (low range)
// - range select set picks the high-range falling comparator
// - high range chosen while not above rising trip resets at once
// - reset request held until supply is above the rising trip
// - monitor and reset generation enabled by default out of reset
// - power-disable stops monitor: no resets, no flag updates
// - reset-disable blocks resets while flag still tracks supply
// - in stop, monitor runs only with power-disable clear, stop-enable set
// - active in stop with resets enabled, a drop issues a reset
// - in wait an enabled monitor stays active and may reset
// - both disables clear, outside stop or with stop-enable set: reset whenever supply is below falling trip
// - trip-range select lives in a write-once configuration register
// - the monitor itself raises no interrupt request
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module supply_monitor
  import supply_monitor_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog comparator, asynchronous levels
  input wire logic low_below_fall,
  input wire logic low_above_rise,
  input wire logic high_below_fall,
  input wire logic high_above_rise,
  // low-power mode indications from system
  input wire logic stop_mode,
  input wire logic wait_mode,
  // results
  output logic supply_low_flag,
  output logic reset_request,
  output logic irq
);
  logic [3:0] cmp_sync;
  compare_s cmp;
  monitor_cfg_s cfg_r;
  logic cfg_locked_r;
  monitor_state_e state_r;
  monitor_state_e state_nxt;
  logic flag_r;
  logic rst_r;
  logic active;
  logic rst_allowed;
  logic flag_nxt;
  logic rst_nxt;
  logic trip_armed;
  logic cfg_wr;
  logic range_chk_r;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_enable;
  logic irq_w;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic irq_r;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic [7:0] rd_byte;

  compare_sync #(.WIDTH(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({low_below_fall, low_above_rise, high_below_fall, high_above_rise}),
    .sync_out(cmp_sync)
  );

  // comparator pair picked by the range select
  always_comb begin
    if (cfg_r.trip_select) begin
      cmp.below_fall = cmp_sync[1];
      cmp.above_rise = cmp_sync[0];
    end else begin
      cmp.below_fall = cmp_sync[3];
      cmp.above_rise = cmp_sync[2];
    end
  end

  // monitor gating by config and low-power mode
  always_comb begin
    active = !cfg_r.power_disable;
    if (stop_mode) active = !cfg_r.power_disable && cfg_r.stop_enable;
    rst_allowed = active && !cfg_r.reset_disable;
  end

  // hysteretic flag
  always_comb begin
    flag_nxt = flag_r;
    if (active) begin
      if (cmp.below_fall) flag_nxt = 1'b1;
      else if (cmp.above_rise) flag_nxt = 1'b0;
    end
  end

  // trip below falling level, or just after high range chosen while not above rising level
  assign trip_armed = cmp.below_fall || (range_chk_r && !cmp.above_rise);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RUN_ST: begin
        if (!active) state_nxt = OFF_ST;
        else if (rst_allowed && trip_armed) state_nxt = LOW_RESET_ST;
      end
      LOW_RESET_ST: begin
        if (!rst_allowed) state_nxt = active ? RUN_ST : OFF_ST;
        else if (cmp.above_rise) state_nxt = RUN_ST;
      end
      OFF_ST: begin
        if (active && rst_allowed && trip_armed) state_nxt = LOW_RESET_ST;
        else if (active) state_nxt = RUN_ST;
      end
      default: state_nxt = RUN_ST;
    endcase
  end

  assign rst_nxt = (state_nxt == LOW_RESET_ST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_r <= RUN_ST;
    else state_r <= state_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_r <= 1'b0;
    else flag_r <= flag_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rst_r <= 1'b0;
    else rst_r <= rst_nxt;
  end

  // apb decode, zero wait states
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  always_comb begin
    case (paddr)
      STATUS_OFS, CONFIG_OFS, MODE_OFS, EVT_STATUS_OFS, EVT_CLEAR_OFS, EVT_ENABLE_OFS:
        addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // write-once configuration
  assign cfg_wr = wr_acc && paddr == CONFIG_OFS && pstrb[0] && !cfg_locked_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RESET;
      cfg_locked_r <= 1'b0;
    end else if (cfg_wr) begin
      cfg_r.stop_enable <= pwdata[STOP_EN_BIT];
      cfg_r.power_disable <= pwdata[PWR_DIS_BIT];
      cfg_r.trip_select <= pwdata[TRIP_SEL_BIT];
      cfg_r.reset_disable <= pwdata[RST_DIS_BIT];
      cfg_locked_r <= 1'b1;
    end
  end

  // one-cycle range check once the high range is chosen; later band stays hysteretic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) range_chk_r <= 1'b0;
    else range_chk_r <= cfg_wr && pwdata[TRIP_SEL_BIT];
  end

  // events: flag set, flag clear, reset request issued
  assign evt_set[EVT_FALL_BIT] = flag_nxt && !flag_r;
  assign evt_set[EVT_RISE_BIT] = !flag_nxt && flag_r;
  assign evt_set[EVT_RST_BIT] = rst_nxt && !rst_r;

  event_irq #(.N(EVT_W)) u_evt (
    .pclk(pclk),
    .presetn(presetn),
    .evt_set(evt_set),
    .clr_bits(pwdata[EVT_W-1:0]),
    .clr_we(wr_acc && paddr == EVT_CLEAR_OFS && pstrb[0]),
    .en_bits(pwdata[EVT_W-1:0]),
    .en_we(wr_acc && paddr == EVT_ENABLE_OFS && pstrb[0]),
    .status(evt_status),
    .enable(evt_enable),
    .irq(irq_w)
  );

  // read mux
  always_comb begin
    rd_byte = 8'h00;
    case (paddr)
      STATUS_OFS: begin
        rd_byte[LOW_FLAG_BIT] = flag_r;
        rd_byte[RST_REQ_BIT] = rst_r;
        rd_byte[ACTIVE_BIT] = active;
      end
      CONFIG_OFS: begin
        rd_byte[STOP_EN_BIT] = cfg_r.stop_enable;
        rd_byte[PWR_DIS_BIT] = cfg_r.power_disable;
        rd_byte[TRIP_SEL_BIT] = cfg_r.trip_select;
        rd_byte[RST_DIS_BIT] = cfg_r.reset_disable;
        rd_byte[CFG_LOCK_BIT] = cfg_locked_r;
      end
      MODE_OFS: begin
        rd_byte[WAIT_BIT] = wait_mode;
        rd_byte[STOP_BIT] = stop_mode;
      end
      EVT_STATUS_OFS: rd_byte[EVT_W-1:0] = evt_status;
      EVT_ENABLE_OFS: rd_byte[EVT_W-1:0] = evt_enable;
      default: rd_byte = 8'h00;
    endcase
  end

  // read data and error captured in setup, valid in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r <= rd_acc ? zext8(rd_byte) : 32'h00000000;
      pslverr_r <= !addr_ok;
    end
  end

  // interrupt comes only from the bus-side event logic, not the monitor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_r <= 1'b0;
    else irq_r <= irq_w;
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign pready = 1'b1;
  assign supply_low_flag = flag_r;
  assign reset_request = rst_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// ==== rtl/supply_monitor_pkg.sv ====
// package: register map, field positions and carriers for the supply monitor
package supply_monitor_pkg;

  localparam int ADDR_W = 12;
  // register byte offsets
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] CONFIG_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] MODE_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] EVT_STATUS_OFS = 12'h00C;
  localparam logic [ADDR_W-1:0] EVT_CLEAR_OFS = 12'h010;
  localparam logic [ADDR_W-1:0] EVT_ENABLE_OFS = 12'h014;

  // status register fields
  localparam int LOW_FLAG_BIT = 0;
  localparam int RST_REQ_BIT = 1;
  localparam int ACTIVE_BIT = 2;

  // configuration register fields (write once)
  localparam int STOP_EN_BIT = 0;
  localparam int PWR_DIS_BIT = 1;
  localparam int TRIP_SEL_BIT = 2;
  localparam int RST_DIS_BIT = 3;
  localparam int CFG_LOCK_BIT = 7;

  // mode register fields
  localparam int WAIT_BIT = 0;
  localparam int STOP_BIT = 1;

  // event bits
  localparam int EVT_FALL_BIT = 0;
  localparam int EVT_RISE_BIT = 1;
  localparam int EVT_RST_BIT = 2;
  localparam int EVT_W = 3;

  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [EVT_W-1:0] EVT_EN_RESET = 3'h0;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic stop_enable;
    logic power_disable;
    logic trip_select;
    logic reset_disable;
  } monitor_cfg_s;

  typedef struct packed {
    logic below_fall;
    logic above_rise;
  } compare_s;

  typedef enum logic [1:0] {
    RUN_ST = 2'b00,
    LOW_RESET_ST = 2'b01,
    OFF_ST = 2'b10
  } monitor_state_e;

  // word from an 8-bit field, upper bits zero
  function automatic logic [31:0] zext8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

endpackage

// ==== rtl/compare_sync.sv ====
// two-stage synchroniser for the comparator outputs
`timescale 1ns/1ps
`default_nettype none
module compare_sync
  import supply_monitor_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw and synchronised levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule
`default_nettype wire

// ==== rtl/event_irq.sv ====
// sticky event status with clear, enable and one level interrupt
`timescale 1ns/1ps
`default_nettype none
module event_irq
  import supply_monitor_pkg::*;
#(
  parameter int N = EVT_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // event pulses and software control
  input wire logic [N-1:0] evt_set,
  input wire logic [N-1:0] clr_bits,
  input wire logic clr_we,
  input wire logic [N-1:0] en_bits,
  input wire logic en_we,
  // state
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);
  logic [N-1:0] status_r;
  logic [N-1:0] enable_r;
  logic irq_r;
  logic [N-1:0] status_nxt;

  // set wins over clear
  always_comb begin
    status_nxt = status_r;
    if (clr_we) status_nxt = status_nxt & ~clr_bits;
    status_nxt = status_nxt | evt_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_r <= '0;
    else status_r <= status_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) enable_r <= EVT_EN_RESET;
    else if (en_we) enable_r <= en_bits;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_r <= 1'b0;
    else irq_r <= |(status_nxt & (en_we ? en_bits : enable_r));
  end

  assign status = status_r;
  assign enable = enable_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// ==== verif/supply_model.sv ====
// supply level and range comparator model for the monitor bench
`timescale 1ns/1ps
`default_nettype none
module supply_model #(
  parameter int LF = 40,
  parameter int LR = 50,
  parameter int HF = 80,
  parameter int HR = 90
) (
  // supply level
  input wire logic [7:0] lvl,
  // comparator levels
  output logic lbf,
  output logic lar,
  output logic hbf,
  output logic har
);
  assign lbf = lvl < LF;
  assign lar = lvl > LR;
  assign hbf = lvl < HF;
  assign har = lvl > HR;
endmodule
`default_nettype wire

// ==== verif/supply_monitor_props.sv ====
// port assertions for the supply monitor
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_props
  import supply_monitor_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  // comparator and mode
  input wire logic low_below_fall,
  input wire logic low_above_rise,
  input wire logic high_below_fall,
  input wire logic high_above_rise,
  input wire logic stop_mode,
  // results
  input wire logic supply_low_flag,
  input wire logic reset_request
);
  logic [3:0] cfg_r;
  logic lock_r;
  logic bf, ar, act, rd, cfg_wr;
  assign cfg_wr = psel && penable && pwrite && paddr == CONFIG_OFS && pstrb[0] && !lock_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= 4'h0;
      lock_r <= 1'b0;
    end else if (cfg_wr) begin
      cfg_r <= pwdata[3:0];
      lock_r <= 1'b1;
    end
  end
  assign bf = cfg_r[TRIP_SEL_BIT] ? high_below_fall : low_below_fall;
  assign ar = cfg_r[TRIP_SEL_BIT] ? high_above_rise : low_above_rise;
  assign rd = cfg_r[RST_DIS_BIT] || cfg_r[PWR_DIS_BIT];
  assign act = !cfg_r[PWR_DIS_BIT] && (!stop_mode || cfg_r[STOP_EN_BIT]);
  sequence s_low;
    (bf && act)[*4];
  endsequence
  sequence s_trip;
    (bf && act && !rd)[*4];
  endsequence
  sequence s_range;
    (!high_above_rise)[*3] ##0 (cfg_wr && pwdata[TRIP_SEL_BIT]) ##1 (act && !rd);
  endsequence
  sequence s_wait;
    (!ar && act && !rd)[*4];
  endsequence
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_high: assert property (pready) else $error("pready low");
  a_flag_sets: assert property (s_low |-> supply_low_flag) else $error("flag not set");
  a_flag_clears: assert property ((ar && act)[*4] |-> !supply_low_flag)
    else $error("flag not cleared");
  a_flag_holds: assert property ((!bf && !ar && act)[*5] |-> $stable(supply_low_flag))
    else $error("flag moved in band");
  a_reset_trips: assert property (s_trip |-> reset_request) else $error("no reset");
  a_range_reset: assert property (s_range |=> reset_request) else $error("no range reset");
  a_reset_holds: assert property (s_wait ##0 reset_request |=> reset_request)
    else $error("reset dropped early");
  a_reset_blocked: assert property (rd[*4] |-> !reset_request)
    else $error("reset while disabled");
  a_off_frozen: assert property ((!act)[*4] |-> $stable(supply_low_flag))
    else $error("flag moved while off");
  a_unmapped_err: assert property (psel && penable && paddr > EVT_ENABLE_OFS |-> pslverr)
    else $error("no error on unmapped");
endmodule
bind supply_monitor supply_monitor_props u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .low_below_fall, .low_above_rise,
  .high_below_fall, .high_above_rise, .stop_mode, .supply_low_flag, .reset_request);
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the supply monitor
`timescale 1ns/1ps
`default_nettype none
module tb
  import supply_monitor_pkg::*;
;
  localparam int LF = 40, LR = 50, HF = 80, HR = 90;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, flag, rreq, irq;
  logic lbf, lar, hbf, har, stop_mode, wait_mode, ef, er, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb, cfg;
  logic [7:0] lvl;
  int seed = 22, n_errors = 0, total_checks = 0, cyc = 0;
  supply_model #(.LF(LF), .LR(LR), .HF(HF), .HR(HR)) u_sup (.lvl, .lbf, .lar, .hbf, .har);
  supply_monitor DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .low_below_fall(lbf), .low_above_rise(lar),
    .high_below_fall(hbf), .high_above_rise(har), .stop_mode, .wait_mode,
    .supply_low_flag(flag), .reset_request(rreq), .irq);
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  task end_sim;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task step(input logic [7:0] v);
    int f, r;
    logic act;
    f = cfg[TRIP_SEL_BIT] ? HF : LF;
    r = cfg[TRIP_SEL_BIT] ? HR : LR;
    act = !cfg[PWR_DIS_BIT] && (!stop_mode || cfg[STOP_EN_BIT]);
    lvl <= v;
    repeat (5) @(posedge pclk);
    if (act && v < f) ef = 1'b1;
    else if (act && v > r) ef = 1'b0;
    if (!act || cfg[RST_DIS_BIT]) er = 1'b0;
    else if (v < f) er = 1'b1;
    else if (v > r) er = 1'b0;
    chk("flag", flag, ef);
    chk("reset", rreq, er);
  endtask
  task phase(input logic [3:0] c, input logic s, input logic w, input logic [7:0] v0);
    stop_mode <= s;
    wait_mode <= w;
    lvl <= v0;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cfg = 4'h0;
    ef = 1'b0;
    er = 1'b0;
    apb(0, CONFIG_OFS, 0);
    chk("cfg0", rdat, 0);
    apb(0, STATUS_OFS, 0);
    chk("stat0", rdat, {29'h0, !s, 2'b00});
    apb(1, CONFIG_OFS, {28'h0, c});
    apb(1, CONFIG_OFS, 32'h0F);
    apb(0, CONFIG_OFS, 0);
    chk("cfg", rdat, {24'h0, 4'h8, c});
    apb(0, MODE_OFS, 0);
    chk("mode", rdat, {30'h0, s, w});
    cfg = c;
    if (c[TRIP_SEL_BIT] && !c[RST_DIS_BIT] && !c[PWR_DIS_BIT] && (!s || c[STOP_EN_BIT]) && v0 <= HR)
      er = 1'b1;
    chk("range reset", rreq, er);
    step(LF);
    step(LR);
    step(HF);
    step(HR);
    repeat (30) step(8'({$random(seed)} % 100));
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    stop_mode = 1'b0;
    wait_mode = 1'b0;
    lvl = 8'd95;
    phase(4'h0, 0, 0, 8'd95);
    phase(4'h4, 0, 0, 8'd95);
    phase(4'h4, 0, 0, 8'd85);
    phase(4'h2, 0, 0, 8'd95);
    phase(4'h0, 1, 0, 8'd95);
    phase(4'h1, 1, 0, 8'd95);
    phase(4'h1, 0, 1, 8'd95);
    phase(4'h8, 0, 0, 8'd95);
    step(8'd95);
    apb(1, EVT_CLEAR_OFS, 32'h7);
    step(8'd10);
    chk("irq mask", irq, 0);
    apb(0, EVT_STATUS_OFS, 0);
    chk("evt set", rdat, 32'h1);
    apb(1, EVT_ENABLE_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq on", irq, 1);
    apb(1, EVT_CLEAR_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq off", irq, 0);
    apb(0, 12'h020, 0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rdat, 0);
    end_sim();
  end
endmodule
`default_nettype wire
